// >>> htf_decode.sv
/*
 Host transport receive decoder: register, set-device-bits and DMA
 activate frame handling with an AXI4-Lite register slave.
 Assumes the link layer presents decoded fields and one-cycle pulses
 synchronous to aclk, and a DMA controller with level handshakes.
*/
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module htf_decode (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Link layer receive side
	input wire logic link_frame_start,
	input wire logic [7:0] link_frame_type,
	input wire logic link_dma_dir_in,
	input wire htf_pkg::htf_regs_s link_reg_fields,
	input wire logic link_reg_field_valid,
	input wire logic link_frame_done,
	input wire htf_pkg::htf_devbits_s link_dev_bits,
	input wire logic link_end_status_valid,
	input wire logic link_end_status_error,
	input wire logic link_illegal_transition,
	input wire logic link_dma_abort,
	input wire logic link_data_dword,
	// Link layer commands
	output htf_pkg::htf_link_cmd_s link_cmd,
	output logic link_send_data,
	// DMA controller
	input wire logic dma_initialized,
	input wire logic dma_transfer_done,
	input wire logic dma_idle,
	input wire logic dma_error,
	output logic dma_activate,
	// Application status
	output logic interrupt_pending,
	output logic app_error,
	output logic [3:0] state_out
);
	htf_pkg::htf_state_e state, next_state;
	htf_pkg::htf_regs_s hold, next_hold, shadow, next_shadow;
	htf_pkg::htf_link_cmd_s next_link_cmd;
	logic [11:0] dword_count, next_dword_count;
	logic aborted, next_aborted;
	logic pend, next_pend, next_app_error, next_dma_activate;
	logic next_link_send_data;
	logic [2:0] ctrl, next_ctrl;
	logic reset_req;
	logic wr_go, irq_clr;

	// Soft reset bit or device reset command as one abort request
	assign reset_req = ctrl[htf_pkg::CTRL_SOFT_RESET_BIT_BIT] |
		ctrl[htf_pkg::CTRL_DEVRST_BIT];

	// Transport state machine next values
	always_comb begin
		next_state = state;
		next_hold = hold;
		next_shadow = shadow;
		next_link_cmd = '0;
		next_dword_count = dword_count;
		next_aborted = aborted;
		next_pend = 1'b0;
		next_app_error = 1'b0;
		next_dma_activate = 1'b0;
		next_link_send_data = 1'b0;
		case (state)
		htf_pkg::transport_idle_state: begin
			// Type indications are only looked at here, one frame at a time
			if (link_frame_start) begin
				if (link_frame_type == htf_pkg::TYPE_REG_D2H)
					next_state = htf_pkg::reg_frame_unpack_state;
				else if (link_frame_type == htf_pkg::TYPE_DEV_BITS)
					next_state = htf_pkg::dev_bits_receive_state;
				else if (link_frame_type == htf_pkg::TYPE_DMA_ACT)
					next_state = htf_pkg::dma_activate_check_state;
			end
		end
		htf_pkg::reg_frame_unpack_state: begin
			if (link_illegal_transition)
				next_state = htf_pkg::transport_idle_state;
			else begin
				if (link_reg_field_valid)
					next_hold = link_reg_fields;
				if (link_frame_done)
					next_state = htf_pkg::reg_frame_status_state;
			end
		end
		htf_pkg::reg_frame_status_state: begin
			if (link_illegal_transition)
				next_state = htf_pkg::transport_idle_state;
			else if (link_end_status_valid) begin
				next_state = htf_pkg::transport_idle_state;
				if (link_end_status_error) begin
					next_link_cmd.error_status = 1'b1;
				end else begin
					next_shadow = hold;
					if (hold.irq)
						next_pend = 1'b1;
				end
			end
		end
		htf_pkg::dev_bits_receive_state: begin
			if (link_illegal_transition)
				next_state = htf_pkg::transport_idle_state;
			else if (link_end_status_valid) begin
				if (link_end_status_error) begin
					next_link_cmd.error_status = 1'b1;
					next_state = htf_pkg::transport_idle_state;
				end else begin
					next_hold.status = {1'b0, link_dev_bits.status_high_field,
						1'b0, link_dev_bits.status_low_field};
					next_hold.error = link_dev_bits.error;
					next_hold.irq = link_dev_bits.irq;
					next_state = htf_pkg::dev_bits_load_state;
				end
			end
		end
		htf_pkg::dev_bits_load_state: begin
			next_shadow.error = hold.error;
			next_shadow.status[6:4] = hold.status[6:4];
			next_shadow.status[2:0] = hold.status[2:0];
			// Busy and data-request are simply not written here
			if (hold.irq && !shadow.status[htf_pkg::BUSY_BIT] &&
				!shadow.status[htf_pkg::DREQ_BIT])
				next_pend = 1'b1;
			next_state = htf_pkg::transport_idle_state;
		end
		htf_pkg::dma_activate_check_state: begin
			next_dword_count = '0;
			next_aborted = 1'b0;
			if (link_illegal_transition)
				next_state = htf_pkg::transport_idle_state;
			else if (link_end_status_valid) begin
				if (link_end_status_error) begin
					next_link_cmd.error_status = 1'b1;
					next_app_error = 1'b1;
					next_state = htf_pkg::transport_idle_state;
				end else if (link_dma_dir_in)
					next_state = htf_pkg::dma_in_transfer_state;
				else
					next_state = htf_pkg::dma_out_wait_init_state;
			end
		end
		htf_pkg::dma_out_wait_init_state: begin
			if (link_illegal_transition)
				next_state = htf_pkg::transport_idle_state;
			else if (reset_req) begin
				next_link_cmd.sync_escape = 1'b1;
				next_state = htf_pkg::transport_idle_state;
			end else if (dma_initialized)
				next_state = htf_pkg::dma_out_transfer_state;
		end
		htf_pkg::dma_out_transfer_state: begin
			next_dma_activate = 1'b1;
			next_link_send_data = 1'b1;
			if (link_illegal_transition)
				next_state = htf_pkg::transport_idle_state;
			else if (reset_req) begin
				next_dma_activate = 1'b0;
				next_link_send_data = 1'b0;
				next_link_cmd.sync_escape = 1'b1;
				next_state = htf_pkg::transport_idle_state;
			end else if (link_dma_abort) begin
				next_dma_activate = 1'b0;
				next_link_send_data = 1'b0;
				next_aborted = 1'b1;
				next_link_cmd.append_crc_end = 1'b1;
				next_state = htf_pkg::dma_end_state;
			end else if (dma_transfer_done) begin
				next_dma_activate = 1'b0;
				next_link_send_data = 1'b0;
				next_state = htf_pkg::dma_end_state;
			end else if (link_data_dword) begin
				next_dword_count = dword_count + 12'h001;
				if (next_dword_count == htf_pkg::MAX_DWORDS) begin
					next_dma_activate = 1'b0;
					next_link_send_data = 1'b0;
					next_link_cmd.close_frame = 1'b1;
					next_state = htf_pkg::dma_end_state;
				end
			end
		end
		htf_pkg::dma_in_transfer_state: begin
			// Controller runs only once initialized; frames held till then
			next_dma_activate = dma_initialized;
			if (link_illegal_transition)
				next_state = htf_pkg::transport_idle_state;
			else if (reset_req) begin
				next_dma_activate = 1'b0;
				next_link_cmd.sync_escape = 1'b1;
				next_state = htf_pkg::transport_idle_state;
			end else if (dma_transfer_done) begin
				next_dma_activate = 1'b0;
				next_state = htf_pkg::dma_end_state;
			end
		end
		htf_pkg::dma_end_state: begin
			if (link_illegal_transition)
				next_state = htf_pkg::transport_idle_state;
			else if (link_dma_abort) begin
				next_link_cmd.append_crc_end = 1'b1;
				next_aborted = 1'b1;
			end else if (dma_idle) begin
				next_app_error = dma_error | aborted;
				next_link_cmd.error_status = dma_error;
				next_state = htf_pkg::transport_idle_state;
			end
		end
		default: next_state = htf_pkg::transport_idle_state;
		endcase
		// Held flag drops on a clear, but a set in the same cycle wins
		next_pend = next_pend | (pend & !irq_clr);
	end

	// Transport state registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= htf_pkg::transport_idle_state;
			hold <= '0;
			shadow <= '0;
			shadow.status <= htf_pkg::STATUS_RESET;
			link_cmd <= '0;
			dword_count <= '0;
			aborted <= 1'b0;
			pend <= 1'b0;
			app_error <= 1'b0;
			dma_activate <= 1'b0;
			link_send_data <= 1'b0;
		end else begin
			state <= next_state;
			hold <= next_hold;
			shadow <= next_shadow;
			link_cmd <= next_link_cmd;
			dword_count <= next_dword_count;
			aborted <= next_aborted;
			pend <= next_pend;
			app_error <= next_app_error;
			dma_activate <= next_dma_activate;
			link_send_data <= next_link_send_data;
		end
	end

	// Mirror flops so every output comes straight from a register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_pending <= 1'b0;
			state_out <= 4'h0;
		end else begin
			interrupt_pending <= next_pend;
			state_out <= next_state;
		end
	end

	// AXI4-Lite slave: write waits for both address and data
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic [7:0] aw_q, next_aw_q;
	logic [31:0] w_q, next_w_q;
	logic aw_have, next_aw_have, w_have, next_w_have;

	assign wr_go = aw_have && w_have && !s_bvalid;
	assign irq_clr = wr_go && aw_q == htf_pkg::CTRL_OFF &&
		w_q[htf_pkg::CTRL_IRQCLR_BIT];

	always_comb begin
		next_aw_have = aw_have;
		next_w_have = w_have;
		next_aw_q = aw_q;
		next_w_q = w_q;
		next_bvalid = s_bvalid;
		next_bresp = s_bresp;
		next_ctrl = ctrl;
		if (s_awvalid && s_awready) begin
			next_aw_have = 1'b1;
			next_aw_q = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			next_w_have = 1'b1;
			next_w_q = s_wstrb[0] ? s_wdata : 32'h00000000;
		end
		if (s_bvalid && s_bready)
			next_bvalid = 1'b0;
		if (wr_go) begin
			next_aw_have = 1'b0;
			next_w_have = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = htf_pkg::RESP_OKAY;
			if (aw_q == htf_pkg::CTRL_OFF)
				next_ctrl = w_q[1:0] == 2'h0 ? 3'h0 : {1'b0, w_q[1:0]};
			else
				next_bresp = htf_pkg::RESP_SLVERR;
		end
		next_awready = !next_aw_have && !next_bvalid;
		next_wready = !next_w_have && !next_bvalid;
		next_rvalid = s_rvalid;
		next_rdata = s_rdata;
		next_rresp = s_rresp;
		if (s_rvalid && s_rready)
			next_rvalid = 1'b0;
		if (s_arvalid && s_arready) begin
			next_rvalid = 1'b1;
			next_rresp = htf_pkg::RESP_OKAY;
			case (s_araddr)
			htf_pkg::CTRL_OFF: next_rdata = {29'h0, ctrl};
			htf_pkg::STAT_OFF: next_rdata = {20'h0, aborted, app_error,
				pend, dma_activate, 4'h0, state};
			htf_pkg::SHADOW_OFF: next_rdata = {shadow.device,
				shadow.sector_count, shadow.error, shadow.status};
			htf_pkg::HOLD_OFF: next_rdata = {hold.device,
				hold.sector_count, hold.error, hold.status};
			htf_pkg::COUNT_OFF: next_rdata = {20'h0, dword_count};
			default: begin
				next_rdata = 32'h00000000;
				next_rresp = htf_pkg::RESP_SLVERR;
			end
			endcase
		end
		next_arready = !next_rvalid;
	end

	// Bus registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h00000000;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= 2'h0;
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h00000000;
			s_rresp <= 2'h0;
			ctrl <= 3'h0;
		end else begin
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			aw_q <= next_aw_q;
			w_q <= next_w_q;
			s_awready <= next_awready;
			s_wready <= next_wready;
			s_bvalid <= next_bvalid;
			s_bresp <= next_bresp;
			s_arready <= next_arready;
			s_rvalid <= next_rvalid;
			s_rdata <= next_rdata;
			s_rresp <= next_rresp;
			ctrl <= next_ctrl;
		end
	end
endmodule

`default_nettype wire

// >>> htf_pkg.sv
/*
 Package for the host transport receive decoder: register offsets,
 field positions, reset values, state encoding and carrier structs.
 Assumes a 32-bit AXI4-Lite register bus and one core clock.
*/
package htf_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STAT_OFF = 8'h04;
	localparam logic [7:0] SHADOW_OFF = 8'h08;
	localparam logic [7:0] HOLD_OFF = 8'h0c;
	localparam logic [7:0] COUNT_OFF = 8'h10;
	// Control register bit positions
	localparam int CTRL_SOFT_RESET_BIT_BIT = 0;
	localparam int CTRL_DEVRST_BIT = 1;
	localparam int CTRL_IRQCLR_BIT = 2;
	// Shadow status bit positions
	localparam int BUSY_BIT = 7;
	localparam int DREQ_BIT = 3;
	// Outbound frame payload limit in dwords
	localparam logic [11:0] MAX_DWORDS = 12'h800;
	localparam logic [7:0] STATUS_RESET = 8'h80;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Frame type codes offered by the link layer
	localparam logic [7:0] TYPE_REG_D2H = 8'h34;
	localparam logic [7:0] TYPE_DEV_BITS = 8'ha1;
	localparam logic [7:0] TYPE_DMA_ACT = 8'h39;

	typedef enum logic [3:0] {
		transport_idle_state = 4'h0,
		reg_frame_unpack_state = 4'h1,
		reg_frame_status_state = 4'h2,
		dev_bits_receive_state = 4'h3,
		dev_bits_load_state = 4'h4,
		dma_activate_check_state = 4'h5,
		dma_out_wait_init_state = 4'h6,
		dma_out_transfer_state = 4'h7,
		dma_end_state = 4'h8,
		dma_in_transfer_state = 4'h9
	} htf_state_e;

	// Register frame content as held and shadowed
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] error;
		logic [7:0] device;
		logic [7:0] sector_count;
		logic [47:0] lba;
		logic irq;
	} htf_regs_s;

	// Set device bits frame fields
	typedef struct packed {
		logic [2:0] status_high_field;
		logic [2:0] status_low_field;
		logic [7:0] error;
		logic irq;
	} htf_devbits_s;

	// Commands toward the link layer
	typedef struct packed {
		logic close_frame;
		logic append_crc_end;
		logic sync_escape;
		logic error_status;
	} htf_link_cmd_s;
endpackage

// >>> htf_decode_checker.sv
/*
 Checker for the transport receive decoder: state moves and commands.
 Bound to htf_decode; sees only its ports, one aclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module htf_decode_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link and DMA inputs
	input wire logic link_frame_start,
	input wire logic [7:0] link_frame_type,
	input wire logic link_frame_done,
	input wire logic link_end_status_valid,
	input wire logic link_end_status_error,
	input wire logic link_illegal_transition,
	input wire logic link_dma_abort,
	input wire logic dma_transfer_done,
	input wire logic dma_idle,
	// Decoder outputs
	input wire htf_pkg::htf_link_cmd_s link_cmd,
	input wire logic [3:0] state_out
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// An illegal notice overrides every move outside idle, so it gates the rest
	logic ok;
	assign ok = !link_illegal_transition;
	sequence s_end(st, e);
		state_out == st && link_end_status_valid
			&& link_end_status_error == e && ok;
	endsequence
	property p_enter;
		state_out == htf_pkg::transport_idle_state && link_frame_start
			&& link_frame_type == htf_pkg::TYPE_REG_D2H
			|=> state_out == htf_pkg::reg_frame_unpack_state;
	endproperty
	property p_illegal;
		state_out != htf_pkg::transport_idle_state && !ok
			|=> state_out == htf_pkg::transport_idle_state;
	endproperty
	property p_held;
		state_out == htf_pkg::reg_frame_unpack_state && link_frame_done && ok
			|=> state_out == htf_pkg::reg_frame_status_state;
	endproperty
	property p_reg_good;
		s_end(htf_pkg::reg_frame_status_state, 1'b0)
			|=> state_out == htf_pkg::transport_idle_state
			&& !link_cmd.error_status;
	endproperty
	property p_reg_bad;
		s_end(htf_pkg::reg_frame_status_state, 1'b1)
			|=> state_out == htf_pkg::transport_idle_state
			&& link_cmd.error_status;
	endproperty
	property p_bits_ok;
		s_end(htf_pkg::dev_bits_receive_state, 1'b0)
			|=> state_out == htf_pkg::dev_bits_load_state
			##1 state_out == htf_pkg::transport_idle_state;
	endproperty
	property p_abort;
		state_out == htf_pkg::dma_out_transfer_state && link_dma_abort && ok
			|=> state_out == htf_pkg::dma_end_state && link_cmd.append_crc_end;
	endproperty
	property p_end_done;
		state_out == htf_pkg::dma_end_state && dma_idle && ok
			&& !link_dma_abort
			|=> state_out == htf_pkg::transport_idle_state;
	endproperty
	property p_in_done;
		state_out == htf_pkg::dma_in_transfer_state && dma_transfer_done && ok
			|=> state_out == htf_pkg::dma_end_state;
	endproperty
	a_enter: assert property (p_enter)
		else $error("register frame not entered");
	a_illegal: assert property (p_illegal)
		else $error("illegal notice did not idle");
	a_held: assert property (p_held)
		else $error("held frame did not reach status check");
	a_reg_good: assert property (p_reg_good)
		else $error("good register ending mishandled");
	a_reg_bad: assert property (p_reg_bad)
		else $error("bad register ending mishandled");
	a_bits_ok: assert property (p_bits_ok)
		else $error("device bits load sequence wrong");
	a_abort: assert property (p_abort)
		else $error("abort not truncated");
	a_end_done: assert property (p_end_done)
		else $error("end state did not idle");
	a_in_done: assert property (p_in_done)
		else $error("inbound done did not reach end");
endmodule
bind htf_decode htf_decode_checker u_chk (.aclk, .aresetn, .link_frame_start,
	.link_frame_type, .link_frame_done, .link_end_status_valid,
	.link_end_status_error, .link_illegal_transition, .link_dma_abort,
	.dma_transfer_done, .dma_idle, .link_cmd, .state_out);
`default_nettype wire

// >>> htf_dma_model.sv
/*
 DMA controller stand-in: initialized a few cycles after the bench arms
 it, finishes or fails on request. Assumes one clock shared with bench.
*/
`timescale 1ns/1ps
`default_nettype none
module htf_dma_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench controls
	input wire logic arm,
	input wire logic finish,
	input wire logic fail,
	// Controller handshake
	input wire logic dma_activate,
	output logic dma_initialized,
	output logic dma_transfer_done,
	output logic dma_idle,
	output logic dma_error
);
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	// Setup delay, so the decoder is seen waiting while it runs
	always_comb begin
		next_cnt = cnt;
		if (!arm) next_cnt = 3'h0;
		else if (cnt != 3'h4) next_cnt = cnt + 3'h1;
	end
	always_ff @(posedge aclk) begin
		cnt <= aresetn ? next_cnt : 3'h0;
	end
	// Done only while activated; idle once released or finished
	assign dma_initialized = cnt == 3'h4;
	assign dma_transfer_done = finish && dma_activate;
	assign dma_idle = !dma_activate || finish;
	assign dma_error = fail;
endmodule
`default_nettype wire

// >>> htf_decode_tb.sv
/*
 Bench for the transport receive decoder: link events, register bus,
 state, shadow and command checks. Assumes htf_dma_model as controller.
*/
`timescale 1ns/1ps
`default_nettype none
module htf_decode_tb;
	// Event codes: start, field, done, end, illegal, abort
	localparam logic [5:0] ST = 6'h20, FLD = 6'h10, DN = 6'h08;
	localparam logic [5:0] EN = 6'h04, IL = 6'h02, AB = 6'h01;
	logic aclk = 1'b0;
	logic aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
	logic s_bready, s_arvalid, s_arready, s_rvalid, s_rready, fail, esc;
	logic link_dma_dir_in, link_end_status_error, link_data_dword, arm;
	logic link_send_data, dma_initialized, dma_transfer_done, dma_idle;
	logic dma_error, dma_activate, interrupt_pending, app_error, finish;
	logic [7:0] s_awaddr, s_araddr, link_frame_type;
	logic [31:0] s_wdata, s_rdata, d;
	logic [3:0] s_wstrb, state_out;
	logic [1:0] s_bresp, s_rresp, r;
	logic [5:0] ev;
	wire logic link_frame_start, link_reg_field_valid, link_frame_done;
	wire logic link_end_status_valid, link_illegal_transition, link_dma_abort;
	htf_pkg::htf_regs_s link_reg_fields;
	htf_pkg::htf_devbits_s link_dev_bits;
	htf_pkg::htf_link_cmd_s link_cmd;
	int mismatches, check_count;
	assign {link_frame_start, link_reg_field_valid, link_frame_done,
		link_end_status_valid, link_illegal_transition, link_dma_abort} = ev;
	always #5 aclk = ~aclk;
	// Sticky record of an escape request toward the link
	always @(posedge aclk) if (link_cmd.sync_escape) esc <= 1'b1;
	htf_decode u_dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
		.s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
		.s_rvalid, .s_rready, .link_frame_start, .link_frame_type,
		.link_dma_dir_in, .link_reg_fields, .link_reg_field_valid,
		.link_frame_done, .link_dev_bits, .link_end_status_valid,
		.link_end_status_error, .link_illegal_transition, .link_dma_abort,
		.link_data_dword, .link_cmd, .link_send_data, .dma_initialized,
		.dma_transfer_done, .dma_idle, .dma_error, .dma_activate,
		.interrupt_pending, .app_error, .state_out);
	htf_dma_model u_dma (.aclk, .aresetn, .arm, .finish, .fail,
		.dma_activate, .dma_initialized, .dma_transfer_done, .dma_idle,
		.dma_error);
	// Compare and count; an unknown never matches
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic cs(input htf_pkg::htf_state_e e);
		#1 chk({28'h0, state_out}, {28'h0, e});
	endtask
	// Bounded wait for a state, then check it
	task automatic ws(input htf_pkg::htf_state_e e);
		repeat (60) if (state_out !== e) @(posedge aclk) #1;
		cs(e);
	endtask
	task automatic pulse(input logic [5:0] m);
		@(posedge aclk);
		ev <= m;
		@(posedge aclk);
		ev <= 6'h0;
	endtask
	task automatic start(input logic [7:0] t, input logic e);
		@(posedge aclk);
		link_frame_type <= t;
		link_end_status_error <= e;
		ev <= ST;
		@(posedge aclk);
		ev <= 6'h0;
	endtask
	// Bus write: address and data offered together, held until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= wd;
		{s_awvalid, s_wvalid, s_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid);
		r = s_bresp;
		s_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_araddr <= a;
		{s_arvalid, s_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid);
		d = s_rdata;
		r = s_rresp;
		s_rready <= 1'b0;
	endtask
	// Register frames: first ends bad, second good; holding seen first
	task automatic t_reg();
		rd(8'h40);
		chk({d[29:0], r}, {30'h0, htf_pkg::RESP_SLVERR});
		link_reg_fields <= '{8'h50, 8'h01, 8'ha0, 8'h02, 48'h0, 1'b1};
		for (int i = 0; i < 2; i++) begin
			start(htf_pkg::TYPE_REG_D2H, i == 0);
			cs(htf_pkg::reg_frame_unpack_state);
			pulse(FLD);
			pulse(DN);
			cs(htf_pkg::reg_frame_status_state);
			rd(htf_pkg::HOLD_OFF);
			chk(d, 32'ha0020150);
			rd(htf_pkg::SHADOW_OFF);
			chk(d, 32'h00000080);
			cs(htf_pkg::reg_frame_status_state);
			pulse(EN);
			cs(htf_pkg::transport_idle_state);
			chk({31'h0, interrupt_pending}, {31'h0, i[0]});
		end
		rd(htf_pkg::SHADOW_OFF);
		chk(d, 32'ha0020150);
	endtask
	// Set device bits with a cleared pending flag beforehand
	task automatic bits(input htf_pkg::htf_devbits_s b, input logic e,
		input logic [31:0] sh, input logic p);
		wr(htf_pkg::CTRL_OFF, 32'h4);
		link_dev_bits <= b;
		start(htf_pkg::TYPE_DEV_BITS, e);
		cs(htf_pkg::dev_bits_receive_state);
		repeat (3) @(posedge aclk);
		cs(htf_pkg::dev_bits_receive_state);
		pulse(EN);
		ws(htf_pkg::transport_idle_state);
		rd(htf_pkg::SHADOW_OFF);
		chk(d, sh);
		chk({31'h0, interrupt_pending}, {31'h0, p});
	endtask
	task automatic t_bits();
		bits('{3'h5, 3'h2, 8'h44, 1'b1}, 1'b0, 32'ha0024452, 1'b1);
		bits('{3'h7, 3'h7, 8'hff, 1'b1}, 1'b1, 32'ha0024452, 1'b0);
		link_reg_fields <= '{8'h88, 8'h01, 8'ha0, 8'h02, 48'h0, 1'b0};
		start(htf_pkg::TYPE_REG_D2H, 1'b0);
		pulse(FLD);
		pulse(DN);
		pulse(EN);
		bits('{3'h0, 3'h7, 8'h00, 1'b1}, 1'b0, 32'ha002008f, 1'b0);
	endtask
	// Activate frame with a given direction, ending without error
	task automatic act(input logic dir);
		link_dma_dir_in <= dir;
		start(htf_pkg::TYPE_DMA_ACT, 1'b0);
		cs(htf_pkg::dma_activate_check_state);
		pulse(EN);
	endtask
	task automatic t_dma();
		arm <= 1'b0;
		act(1'b0);
		repeat (3) @(posedge aclk);
		cs(htf_pkg::dma_out_wait_init_state);
		arm <= 1'b1;
		ws(htf_pkg::dma_out_transfer_state);
		@(posedge aclk);
		link_data_dword <= 1'b1;
		#1 chk({30'h0, dma_activate, link_send_data}, 32'h3);
		repeat (2048) @(posedge aclk);
		link_data_dword <= 1'b0;
		#1 chk({31'h0, link_cmd.close_frame}, 32'h1);
		cs(htf_pkg::dma_end_state);
		ws(htf_pkg::transport_idle_state);
		fail <= 1'b1;
		act(1'b0);
		ws(htf_pkg::dma_out_transfer_state);
		pulse(AB);
		#1 chk({31'h0, link_cmd.append_crc_end}, 32'h1);
		ws(htf_pkg::transport_idle_state);
		chk({31'h0, app_error}, 32'h1);
		fail <= 1'b0;
		arm <= 1'b0;
		act(1'b0);
		ws(htf_pkg::dma_out_wait_init_state);
		esc <= 1'b0;
		wr(htf_pkg::CTRL_OFF, 32'h1);
		ws(htf_pkg::transport_idle_state);
		chk({31'h0, esc}, 32'h1);
		wr(htf_pkg::CTRL_OFF, 32'h0);
		// Device reset request while outbound data is moving
		arm <= 1'b1;
		act(1'b0);
		ws(htf_pkg::dma_out_transfer_state);
		esc <= 1'b0;
		wr(htf_pkg::CTRL_OFF, 32'h2);
		ws(htf_pkg::transport_idle_state);
		chk({30'h0, esc, dma_activate}, 32'h2);
		wr(htf_pkg::CTRL_OFF, 32'h0);
		arm <= 1'b1;
		act(1'b0);
		ws(htf_pkg::dma_out_transfer_state);
		pulse(IL);
		cs(htf_pkg::transport_idle_state);
		act(1'b1);
		cs(htf_pkg::dma_in_transfer_state);
		repeat (2) @(posedge aclk);
		#1 chk({31'h0, dma_activate}, 32'h1);
		@(posedge aclk);
		finish <= 1'b1;
		@(posedge aclk);
		cs(htf_pkg::dma_end_state);
		ws(htf_pkg::transport_idle_state);
		finish <= 1'b0;
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Main sequence after a 16-cycle reset
	initial begin
		{aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{s_awaddr, s_araddr, link_frame_type, s_wdata, ev} = '0;
		{link_dma_dir_in, link_end_status_error, link_data_dword} = '0;
		{arm, finish, fail, esc} = '0;
		s_wstrb = 4'hf;
		link_reg_fields = '0;
		link_dev_bits = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_reg();
		t_bits();
		t_dma();
		give_verdict();
	end
	// Watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		give_verdict();
	end
endmodule
`default_nettype wire
